// ===== rtl/gssp_pkg.sv
// shared constants and carrier types for the gpio / sd shared pin block
package gssp_pkg;

  // ----------------------------------------------------------------
  // clock rates and sd clock divider
  // ----------------------------------------------------------------
  localparam int unsigned SYS_CLK_HZ    = 10_000_000;  // sys_clk rate
  localparam int unsigned SD_CLK_MAX_HZ = 48_000_000;  // sd clock ceiling
  localparam int unsigned HALF_W        = 4;           // divider counter width
  // half period in sys_clk cycles, rounded up so the ceiling is never passed
  localparam int unsigned SD_HALF_INT   = (SYS_CLK_HZ + 2 * SD_CLK_MAX_HZ - 1) / (2 * SD_CLK_MAX_HZ);
  localparam logic [HALF_W-1:0] SD_HALF_CYCLES = (SD_HALF_INT < 1) ? 4'h1 : HALF_W'(SD_HALF_INT);

  // ----------------------------------------------------------------
  // positions of the sd signals on the general-purpose output pins
  // ----------------------------------------------------------------
  localparam int unsigned PIN_CLK = 0;  // sd clock
  localparam int unsigned PIN_CMD = 1;  // command / response
  localparam int unsigned PIN_WP  = 2;  // write-protect sense
  localparam int unsigned PIN_CD  = 3;  // card detect sense
  // positions inside the synchronised pin vector {gen_output, gen_input}
  localparam int unsigned SYNC_GO = 4;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] RST_OE   = 4'h0;
  localparam logic [3:0] RST_VAL  = 4'h0;
  localparam logic       RST_BIT  = 1'b0;

  // one bit slot of the sd link: command line and four data lines
  typedef struct packed {
    logic       cmd;
    logic [3:0] dat;
  } gssp_bit_t;

  // drive values and enables of a group of four shared pins
  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe;
  } gssp_drive_t;

endpackage : gssp_pkg

// ===== rtl/gssp_pin_mux.sv
// pin multiplexer sharing eight connector pins between gpio and an sd card link
//
// What this block does
// - four general inputs double as the four bidirectional sd data lines.
// - four general outputs double as sd clock, command, write-protect, card-detect.
// - each sd clock period carries one command bit and one bit per data line.
// - sd clock never runs faster than 48 MHz.
// - during card initialisation the command line only pulls low or releases.
// - after initialisation the sender drives the command line push-pull.
// - each data line is bidirectional, push-pull, on its matching general input pin.
// - in sd use the fourth general output pin senses card presence.
// - in sd use the third general output pin senses the write-protect tab.
`timescale 1ns/1ps

module gssp_pin_mux
  import gssp_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // user side
  input  wire logic        sd_mode,
  input  wire logic        sd_clk_en,
  input  wire logic        cmd_od_mode,
  input  wire logic [3:0]  gpo_value,
  output logic      [3:0]  gpi_value,
  input  wire gssp_bit_t   tx_bit,
  input  wire gssp_bit_t   tx_oe,
  output logic             bit_take,
  output gssp_bit_t        rx_bit,
  output logic             bit_valid,
  output logic             card_present,
  output logic             write_protected,
  // shared pins
  input  wire logic [3:0]  gen_input_in,
  output logic      [3:0]  gen_input_out,
  output logic      [3:0]  gen_input_oe,
  input  wire logic [3:0]  gen_output_in,
  output logic      [3:0]  gen_output_out,
  output logic      [3:0]  gen_output_oe
);

  // ----------------------------------------------------------------
  // pin input synchronisers
  // ----------------------------------------------------------------
  logic [7:0]        sync_a;
  logic [7:0]        sync_b;
  logic [HALF_W-1:0] div_cnt;
  logic              sd_clk;
  logic              run;
  logic              tick;
  logic              fall_evt;
  logic              rise_evt;
  logic              cmd_drv;
  logic              cmd_val;
  logic [3:0]        dat_drv;
  logic [3:0]        dat_val;
  gssp_drive_t       next_gi;
  gssp_drive_t       next_go;

  // two flops; only sync_b is looked at by the rest of the block
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_a <= 8'h00;
      sync_b <= 8'h00;
    end else begin
      sync_a <= {gen_output_in, gen_input_in};
      sync_b <= sync_a;
    end
  end

  // ----------------------------------------------------------------
  // sd clock divider
  // ----------------------------------------------------------------
  assign run      = sd_mode & sd_clk_en;
  assign tick     = (div_cnt == SD_HALF_CYCLES - 4'h1);
  assign fall_evt = run & tick & sd_clk;
  assign rise_evt = run & tick & ~sd_clk;

  // half period is rounded up, so the clock stays at or below the ceiling
  // stopping mid-period drops the clock low at once; that slot is abandoned
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 4'h0;
      sd_clk  <= RST_BIT;
    end else if (!run) begin
      div_cnt <= 4'h0;
      sd_clk  <= RST_BIT;
    end else if (tick) begin
      div_cnt <= 4'h0;
      sd_clk  <= ~sd_clk;
    end else begin
      div_cnt <= div_cnt + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // bit slots: launch on falling edge, sample on rising edge
  // ----------------------------------------------------------------
  // user bit is consumed exactly once per sd clock period
  assign bit_take = fall_evt;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_drv <= RST_BIT;
      cmd_val <= RST_BIT;
      dat_drv <= RST_OE;
      dat_val <= RST_VAL;
    end else if (!sd_mode) begin
      cmd_drv <= RST_BIT;
      cmd_val <= RST_BIT;
      dat_drv <= RST_OE;
      dat_val <= RST_VAL;
    end else if (fall_evt) begin
      cmd_drv <= tx_oe.cmd;
      cmd_val <= tx_bit.cmd;
      dat_drv <= tx_oe.dat;
      dat_val <= tx_bit.dat;
    end
  end

  // one sample of command and data per rising edge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_bit    <= '0;
      bit_valid <= RST_BIT;
    end else begin
      bit_valid <= rise_evt;
      if (rise_evt) begin
        rx_bit.cmd <= sync_b[SYNC_GO + PIN_CMD];
        rx_bit.dat <= sync_b[3:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // pin drive selection
  // ----------------------------------------------------------------
  // all eight pins switch between gpio and sd drive together on sd_mode; the clock pin stays an output in both
  always_comb begin
    next_gi = '0;
    next_go = '0;
    if (sd_mode) begin
      next_gi.out = dat_val;
      next_gi.oe  = dat_drv;
      next_go.out[PIN_CLK] = sd_clk;
      next_go.oe[PIN_CLK]  = 1'b1;
      if (cmd_od_mode) begin
        // open drain: drive only a low, release for a high
        next_go.out[PIN_CMD] = 1'b0;
        next_go.oe[PIN_CMD]  = cmd_drv & ~cmd_val;
      end else begin
        next_go.out[PIN_CMD] = cmd_val;
        next_go.oe[PIN_CMD]  = cmd_drv;
      end
      // sense pins stay released so the socket switches can be read
      next_go.oe[PIN_WP] = 1'b0;
      next_go.oe[PIN_CD] = 1'b0;
    end else begin
      next_go.out = gpo_value;
      next_go.oe  = 4'hf;
    end
  end

  // registered pins keep clock and data aligned to the same edge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gen_input_out  <= RST_VAL;
      gen_input_oe   <= RST_OE;
      gen_output_out <= RST_VAL;
      gen_output_oe  <= RST_OE;
    end else begin
      gen_input_out  <= next_gi.out;
      gen_input_oe   <= next_gi.oe;
      gen_output_out <= next_go.out;
      gen_output_oe  <= next_go.oe;
    end
  end

  // ----------------------------------------------------------------
  // status toward the user
  // ----------------------------------------------------------------
  // card detect is active low at the pin; both read zero in gpio use
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gpi_value       <= RST_VAL;
      card_present    <= RST_BIT;
      write_protected <= RST_BIT;
    end else begin
      gpi_value       <= sync_b[3:0];
      card_present    <= sd_mode & ~sync_b[SYNC_GO + PIN_CD];
      write_protected <= sd_mode & sync_b[SYNC_GO + PIN_WP];
    end
  end

endmodule : gssp_pin_mux

// ===== testbench/gssp_card_model.sv
// sd card socket model: sense lines plus card-driven cmd and data
`timescale 1ns/1ps
module gssp_card_model
  import gssp_pkg::*;
(
  input  wire logic      sd_clk,
  input  wire logic      inserted,
  input  wire logic      wp_tab,
  input  wire logic      send,
  input  wire gssp_bit_t send_bit,
  output logic           cd_n,
  output logic           wp,
  output gssp_bit_t      drv_bit,
  output logic           drv_oe
);
  // sense lines, card detect is active low
  assign cd_n = ~inserted;
  assign wp   = wp_tab;
  // launch after the falling clock so the rise sees settled lines
  always @(negedge sd_clk or send) begin
    drv_oe  <= send;
    drv_bit <= send_bit;
  end
endmodule : gssp_card_model

// ===== testbench/gssp_pin_mux_properties.sv
// checker for the shared pin multiplexer ports
`timescale 1ns/1ps
module gssp_pin_mux_chk
  import gssp_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic       sd_mode,
  input wire logic       cmd_od_mode,
  input wire logic [3:0] gpo_value,
  input wire logic       bit_take,
  input wire logic       bit_valid,
  input wire logic       card_present,
  input wire logic       write_protected,
  input wire logic [3:0] gen_input_oe,
  input wire logic [3:0] gen_output_in,
  input wire logic [3:0] gen_output_out,
  input wire logic [3:0] gen_output_oe
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // mode held long enough for registered pins to follow
  sequence s_gpio; (!sd_mode && rst_n) [*3]; endsequence
  sequence s_sd; (sd_mode && rst_n) [*3]; endsequence
  a_gpio_drive: assert property (s_gpio |-> gen_output_oe == 4'hf && gen_output_out == $past(gpo_value))
    else $error("gpio outputs wrong");
  a_gpio_data_in: assert property (s_gpio |-> gen_input_oe == 4'h0)
    else $error("gpio inputs driven");
  a_gpio_quiet: assert property (s_gpio |-> !bit_take && !bit_valid)
    else $error("link active in gpio use");
  a_sd_sense_dir: assert property (s_sd |-> gen_output_oe[3:2] == 2'h0 && gen_output_oe[0])
    else $error("sd pin directions wrong");
  a_card_sense: assert property ((sd_mode && $stable(gen_output_in[3])) [*5] |-> card_present == !gen_output_in[3])
    else $error("card presence wrong");
  a_wp_sense: assert property ((sd_mode && $stable(gen_output_in[2])) [*5] |-> write_protected == gen_output_in[2])
    else $error("write protect wrong");
  a_od_cmd: assert property ((sd_mode && cmd_od_mode) [*2] |-> !(gen_output_oe[1] && gen_output_out[1]))
    else $error("cmd driven high in open drain");
  // internal clock falls one edge after the take, and the registered pin one edge later still
  a_take_clk_fall: assert property (bit_take |-> ##2 $fell(gen_output_out[0]))
    else $error("slot launch without clock fall");
  a_slot_period: assert property (bit_take |=> !bit_take)
    else $error("sd clock too fast");
endmodule : gssp_pin_mux_chk

bind gssp_pin_mux gssp_pin_mux_chk i_chk (.*);

// ===== testbench/tb.sv
// self-checking bench for the gpio / sd shared pin block
`timescale 1ns/1ps
module tb;
  import gssp_pkg::*;
  logic       sys_clk = 1'b0, rst_n = 1'b0, sd_mode = 1'b0, sd_clk_en = 1'b0, cmd_od_mode = 1'b0;
  logic [3:0] gpo_value = 4'h0, gpi_value, gen_input_in, gen_input_out, gen_input_oe;
  logic [3:0] gen_output_in, gen_output_out, gen_output_oe;
  gssp_bit_t  tx_bit = '0, tx_oe = '0, rx_bit, c_bit = '0, c_drv;
  logic       bit_take, bit_valid, card_present, write_protected, cd_n, wp, c_oe;
  logic       c_in = 1'b0, c_wp = 1'b0, c_send = 1'b0;
  int         errors = 0, n_compared = 0;
  always #50 sys_clk = ~sys_clk;
  // released lines float high through the pull-ups
  assign gen_input_in = (gen_input_oe & gen_input_out) | (~gen_input_oe & (c_oe ? c_drv.dat : 4'hf));
  assign gen_output_in = (gen_output_oe & gen_output_out)
                       | (~gen_output_oe & {cd_n, wp, c_oe ? c_drv.cmd : 1'b1, 1'b1});
  gssp_pin_mux i_dut (.*);
  gssp_card_model i_card (.sd_clk(gen_output_out[0]), .inserted(c_in), .wp_tab(c_wp), .send(c_send),
    .send_bit(c_bit), .cd_n(cd_n), .wp(wp), .drv_bit(c_drv), .drv_oe(c_oe));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_of_test
  // bounded wait for a take or valid pulse
  task automatic wait_pulse(input bit rx);
    int n;
    for (n = 0; n < 40; n++) begin
      @(negedge sys_clk);
      if ((rx ? bit_valid : bit_take) === 1'b1) break;
    end
    chk("pulse", 8'h1, 8'(n < 40));
  endtask : wait_pulse
  task automatic t_gpio;
    @(negedge sys_clk);
    gpo_value = 4'ha;
    c_bit = 5'h05;
    c_send = 1'b1;
    repeat (4) @(negedge sys_clk);
    chk("gpo pins", 8'ha, gen_output_out);
    chk("gpo enables", 8'hf, gen_output_oe);
    chk("gpi enables", 8'h0, gen_input_oe);
    chk("gpi value", 8'h5, gpi_value);
  endtask : t_gpio
  task automatic t_sd_rx;
    sd_mode = 1'b1;
    sd_clk_en = 1'b1;
    c_bit = 5'h16;
    c_in = 1'b1;
    c_wp = 1'b1;
    // the card launches on the first pin clock fall; two sync flops push its capture to the fourth rise
    repeat (4) wait_pulse(1'b1);
    chk("rx bit", 8'h16, rx_bit);
    chk("card present", 8'h1, card_present);
    chk("write protect", 8'h1, write_protected);
    chk("sd enables", 8'h1, gen_output_oe);
  endtask : t_sd_rx
  task automatic t_sd_tx;
    c_send = 1'b0;
    tx_oe = 5'h1f;
    tx_bit = 5'h19;
    repeat (2) wait_pulse(1'b0);
    @(negedge sys_clk);
    chk("data out", 8'h9, gen_input_out);
    chk("data oe", 8'hf, gen_input_oe);
    chk("cmd push pull", 8'h3, {gen_output_oe[1], gen_output_out[1]});
    cmd_od_mode = 1'b1;
    repeat (2) wait_pulse(1'b0);
    @(negedge sys_clk);
    chk("cmd od high", 8'h0, gen_output_oe[1]);
    tx_bit = 5'h09;
    repeat (2) wait_pulse(1'b0);
    @(negedge sys_clk);
    chk("cmd od low", 8'h2, {gen_output_oe[1], gen_output_out[1]});
  endtask : t_sd_tx
  initial begin
    repeat (2) @(negedge sys_clk);
    rst_n = 1'b1;
    t_gpio();
    t_sd_rx();
    t_sd_tx();
    end_of_test();
  end
  // watchdog at 1000 sys_clk cycles, far beyond the few dozen cycles the tests need
  initial begin
    #100000;
    errors++;
    end_of_test();
  end
endmodule : tb
